//--- spp_buf.sv
// two-entry receive buffer: output register plus one skid entry
// assumes one clock domain, synchronous active-high reset
module spp_buf (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire spp_pkg::spp_rx_t in_data,
  output logic in_ready,
  output logic out_valid,
  output spp_pkg::spp_rx_t out_data,
  input wire logic out_ready
);
  logic skid_valid;
  spp_pkg::spp_rx_t skid_data;
  logic next_out_valid;
  logic next_skid_valid;
  spp_pkg::spp_rx_t next_out_data;
  spp_pkg::spp_rx_t next_skid_data;
  logic push;
  logic pop;

  assign in_ready = !skid_valid;
  assign push = in_valid && !skid_valid;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_out_valid = out_valid;
    next_out_data = out_data;
    next_skid_valid = skid_valid;
    next_skid_data = skid_data;
    if (pop) begin
      if (skid_valid) begin
        next_out_data = skid_data;
        next_skid_valid = 1'b0;
      end else begin
        next_out_valid = 1'b0;
      end
    end
    if (push) begin
      if (!next_out_valid) begin
        next_out_data = in_data;
        next_out_valid = 1'b1;
      end else begin
        next_skid_data = in_data;
        next_skid_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
      skid_valid <= 1'b0;
      skid_data <= '0;
    end else begin
      out_valid <= next_out_valid;
      out_data <= next_out_data;
      skid_valid <= next_skid_valid;
      skid_data <= next_skid_data;
    end
  end
endmodule

//--- spp_consts.svh
// constants for the serial port block: widths, counts, reset values
// assumes inclusion by the package, the port module and the testbench
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH
`define SPP_WORD_W 8
`define SPP_NSEL 4
`define SPP_SEL_W 2
`define SPP_DIV_W 8
`define SPP_EDGE_W 5
`define SPP_BIT_W 3
`define SPP_LAST_EDGE 5'h0f
`define SPP_LAST_EDGE_EXTRA 5'h11
`define SPP_DUMMY_EDGES 5'h02
`define SPP_EDGES 5'h10
`define SPP_EDGES_EXTRA 5'h12
`define SPP_LAST_BIT 3'h7
`define SPP_SEL_IDLE 4'hf
`endif

//--- spp_partner.sv
// far-side model: serial slave in master mode, serial master in slave mode
// assumes selects active low and a bench in nanoseconds
module spp_partner (
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic [7:0] resp,
  output logic miso,
  output logic sck_link,
  output logic mosi_in,
  output logic ss_n_in,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 100ps;
  int k;
  logic go;
  initial begin
    miso = 1'b0;
    sck_link = 1'b0;
    mosi_in = 1'b0;
    ss_n_in = 1'b1;
    got = 8'h00;
    k = 0;
    go = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // slave side: first bit at select when phase bit set
  always @(negedge sel_n) begin
    k = clock_phase_bit ? 1 : 0;
    if (clock_phase_bit) miso = resp[7];
  end
  // released line shows inverse of last value
  always @(posedge sel_n) begin
    go = 1'b0;
    miso = ~miso;
  end
  // settle edge to idle level before first lead is ignored
  always @(sck) begin
    if (!sel_n && (go || sck !== clock_polarity_bit)) begin
      go = 1'b1;
      if ((sck !== clock_polarity_bit) == clock_phase_bit) got = {got[6:0], mosi};
      else if (k < 8) begin
        miso = resp[7 - k];
        k++;
      end else miso = ~miso;
    end
  end
  ////////////////////////////////////////////////////////////////
  // master side: link clock runs only inside a frame
  task automatic frame(input logic [7:0] b);
    ss_n_in = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_in = b[i];
      #62.5 sck_link = 1'b1;
      #62.5 sck_link = 1'b0;
    end
    #62.5 ss_n_in = 1'b1;
    mosi_in = ~mosi_in;
  endtask
endmodule

//--- spp_pkg.sv
// types shared by the serial port block and its receive buffer
// assumes spp_consts.svh is on the include path
`include "spp_consts.svh"
package spp_pkg;
  typedef struct packed {
    logic [`SPP_DIV_W-1:0] divisor;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic keep;
  } spp_sel_cfg_t;

  typedef struct packed {
    logic [`SPP_WORD_W-1:0] data;
    logic [`SPP_SEL_W-1:0] sel;
  } spp_rx_t;

  typedef enum logic [1:0] {st_idle, st_run, st_done} spp_mst_t;
endpackage

//--- spp_port.sv
// serial peripheral port, master on clk, slave on the link clock
// assumes link pins in slave mode are timed to sck_link by the master
// Summary of operation
// - slave keeps running after enable is cleared
// - returned select field may be wrong
// - select0 keep plus fault detect: no start
// - disabling leaves holding-empty flag unchanged
// - writes while disabled dropped, flag untouched
// - disabled port swallows all dma words
// - divisor 1 mixed with other divisors, cpol1 phase0: extra clock pulse
`include "spp_consts.svh"
module spp_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck_link,
  input wire logic port_enable,
  input wire logic soft_reset_bit,
  input wire logic master_mode,
  input wire logic fault_detect_disable,
  input wire spp_pkg::spp_sel_cfg_t [`SPP_NSEL-1:0] select_cfg,
  input wire logic tx_valid,
  input wire logic [`SPP_WORD_W-1:0] tx_data,
  input wire logic [`SPP_SEL_W-1:0] tx_sel,
  output logic tx_ready,
  output logic tx_holding_empty_flag,
  output logic slave_active,
  output logic rx_valid,
  output spp_pkg::spp_rx_t rx_word,
  input wire logic rx_ready,
  input wire logic miso_in,
  input wire logic mosi_in,
  input wire logic ss_n_in,
  output logic sck_out,
  output logic sck_oe,
  output logic mosi_out,
  output logic mosi_oe,
  output logic miso_out,
  output logic miso_oe,
  output logic [`SPP_NSEL-1:0] sel_n_out
);
  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [`SPP_DIV_W-1:0] half_period(input logic [`SPP_DIV_W-1:0] d);
    half_period = (d == 8'h00) ? 8'h01 : d;
  endfunction

  function automatic logic mixed_div(input spp_pkg::spp_sel_cfg_t [`SPP_NSEL-1:0] c);
    logic one;
    logic other;
    one = 1'b0;
    other = 1'b0;
    for (int i = 0; i < `SPP_NSEL; i++) begin
      if (c[i].divisor == 8'h01) one = 1'b1;
      else other = 1'b1;
    end
    mixed_div = one && other;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // clk domain state
  logic en_q, slave_run, hold_empty;
  logic [`SPP_WORD_W-1:0] hold_data, tx_sr, rx_sr, slv_tx_word;
  logic [`SPP_SEL_W-1:0] hold_sel, cur_sel;
  spp_pkg::spp_mst_t mst;
  logic [`SPP_DIV_W-1:0] div_cnt;
  logic [`SPP_EDGE_W-1:0] edge_cnt;
  logic extra, slv_req, slv_pend;
  logic miso_s1, miso_s2, ss_s1, ss_s2, rxt_s1, rxt_s2, rxt_s3, ack_s1, ack_s2;
  logic next_en_q, next_slave_run, next_hold_empty, next_tx_ready, next_extra;
  logic [`SPP_WORD_W-1:0] next_hold_data, next_tx_sr, next_rx_sr, next_slv_tx_word;
  logic [`SPP_SEL_W-1:0] next_hold_sel, next_cur_sel;
  spp_pkg::spp_mst_t next_mst;
  logic [`SPP_DIV_W-1:0] next_div_cnt;
  logic [`SPP_EDGE_W-1:0] next_edge_cnt, idx;
  logic next_slv_req, next_slv_pend, next_sck, next_mosi, next_sck_oe, next_mosi_oe, next_miso_oe;
  logic [`SPP_NSEL-1:0] next_sel_n;
  logic load_m, stall_start, lead, buf_in_valid, buf_in_ready;
  spp_pkg::spp_rx_t buf_in;
  spp_pkg::spp_sel_cfg_t cfg;
  // link domain state
  logic [`SPP_BIT_W-1:0] l_bit, next_l_bit;
  logic [`SPP_WORD_W-1:0] l_rx_sr, l_rx_word, l_tx_sr, l_tx_word;
  logic [`SPP_WORD_W-1:0] next_l_rx_sr, next_l_rx_word, next_l_tx_sr, next_l_tx_word;
  logic l_tog, l_ack, l_req1, l_req2, next_l_tog, next_l_ack, next_miso;
  logic link_rst;

  assign stall_start = select_cfg[0].keep && !fault_detect_disable;

  ////////////////////////////////////////////////////////////////////////
  // clk domain next state
  always_comb begin
    next_en_q = port_enable;
    next_slave_run = slave_run;
    next_hold_empty = hold_empty;
    next_hold_data = hold_data;
    next_hold_sel = hold_sel;
    next_mst = mst;
    next_tx_sr = tx_sr;
    next_rx_sr = rx_sr;
    next_cur_sel = cur_sel;
    next_div_cnt = div_cnt;
    next_edge_cnt = edge_cnt;
    next_extra = extra;
    next_sck = sck_out;
    next_mosi = mosi_out;
    next_sel_n = sel_n_out;
    next_slv_tx_word = slv_tx_word;
    next_slv_req = slv_req;
    next_slv_pend = slv_pend && (ack_s2 != slv_req);
    load_m = 1'b0;
    buf_in_valid = 1'b0;
    buf_in.data = rx_sr;
    buf_in.sel = hold_sel;
    cfg = select_cfg[cur_sel];
    idx = edge_cnt - (extra ? `SPP_DUMMY_EDGES : 5'h00);
    lead = !idx[0];
    if (en_q && !master_mode) next_slave_run = 1'b1;
    case (mst)
      spp_pkg::st_idle: begin
        if (!slave_run && master_mode && en_q && !hold_empty && buf_in_ready && !stall_start) begin
          cfg = select_cfg[hold_sel];
          load_m = 1'b1;
          next_mst = spp_pkg::st_run;
          next_tx_sr = hold_data;
          next_mosi = hold_data[`SPP_WORD_W-1];
          next_cur_sel = hold_sel;
          next_extra = cfg.clock_polarity_bit && !cfg.clock_phase_bit && mixed_div(select_cfg);
          next_div_cnt = 8'h00;
          next_edge_cnt = 5'h00;
          next_sck = cfg.clock_polarity_bit;
          next_sel_n = ~(4'h1 << hold_sel);
        end else if (!en_q) begin
          next_sel_n = `SPP_SEL_IDLE;
        end
      end
      spp_pkg::st_run: begin
        if (div_cnt == half_period(cfg.divisor) - 8'h01) begin
          next_div_cnt = 8'h00;
          next_sck = !sck_out;
          next_edge_cnt = edge_cnt + 5'h01;
          if (!(extra && edge_cnt < `SPP_DUMMY_EDGES)) begin
            if (cfg.clock_phase_bit == lead) begin
              next_rx_sr = {rx_sr[`SPP_WORD_W-2:0], miso_s2};
            end else if (idx != 5'h00) begin
              next_tx_sr = {tx_sr[`SPP_WORD_W-2:0], 1'b0};
              next_mosi = tx_sr[`SPP_WORD_W-2];
            end
          end
          if (edge_cnt == (extra ? `SPP_LAST_EDGE_EXTRA : `SPP_LAST_EDGE)) next_mst = spp_pkg::st_done;
        end else begin
          next_div_cnt = div_cnt + 8'h01;
        end
      end
      spp_pkg::st_done: begin
        buf_in_valid = 1'b1;
        next_mst = spp_pkg::st_idle;
        if (!cfg.keep) next_sel_n = `SPP_SEL_IDLE;
      end
      default: next_mst = spp_pkg::st_idle;
    endcase
    if (slave_run) begin
      buf_in.data = l_rx_word;
      buf_in_valid = rxt_s2 != rxt_s3;
      if (!hold_empty && !slv_pend) begin
        next_slv_tx_word = hold_data;
        next_slv_req = !slv_req;
        next_slv_pend = 1'b1;
        next_hold_empty = 1'b1;
      end
    end
    if (load_m) next_hold_empty = 1'b1;
    if (tx_valid && tx_ready && en_q) begin
      next_hold_empty = 1'b0;
      next_hold_data = tx_data;
      next_hold_sel = tx_sel;
    end
    next_tx_ready = !port_enable || next_hold_empty;
    next_sck_oe = master_mode && port_enable;
    next_mosi_oe = master_mode && port_enable;
    next_miso_oe = slave_run && !ss_s2;
    if (soft_reset_bit) begin
      next_slave_run = 1'b0;
      next_hold_empty = 1'b1;
      next_mst = spp_pkg::st_idle;
      next_sel_n = `SPP_SEL_IDLE;
      next_slv_pend = 1'b0;
      next_tx_ready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    {miso_s1, miso_s2} <= {miso_in, miso_s1};
    {ss_s1, ss_s2} <= {ss_n_in, ss_s1};
    {rxt_s1, rxt_s2, rxt_s3} <= {l_tog, rxt_s1, rxt_s2};
    {ack_s1, ack_s2} <= {l_ack, ack_s1};
    link_rst <= sys_rst;
    if (sys_rst) begin
      en_q <= 1'b0;
      slave_run <= 1'b0;
      hold_empty <= 1'b1;
      hold_data <= '0;
      hold_sel <= '0;
      mst <= spp_pkg::st_idle;
      tx_sr <= '0;
      rx_sr <= '0;
      cur_sel <= '0;
      div_cnt <= '0;
      edge_cnt <= '0;
      extra <= 1'b0;
      slv_tx_word <= '0;
      slv_req <= 1'b0;
      slv_pend <= 1'b0;
      tx_ready <= 1'b1;
      tx_holding_empty_flag <= 1'b1;
      slave_active <= 1'b0;
      sck_out <= 1'b0;
      mosi_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
      sel_n_out <= `SPP_SEL_IDLE;
    end else begin
      en_q <= next_en_q;
      slave_run <= next_slave_run;
      hold_empty <= next_hold_empty;
      hold_data <= next_hold_data;
      hold_sel <= next_hold_sel;
      mst <= next_mst;
      tx_sr <= next_tx_sr;
      rx_sr <= next_rx_sr;
      cur_sel <= next_cur_sel;
      div_cnt <= next_div_cnt;
      edge_cnt <= next_edge_cnt;
      extra <= next_extra;
      slv_tx_word <= next_slv_tx_word;
      slv_req <= next_slv_req;
      slv_pend <= next_slv_pend;
      tx_ready <= next_tx_ready;
      tx_holding_empty_flag <= next_hold_empty;
      slave_active <= next_slave_run;
      sck_out <= next_sck;
      mosi_out <= next_mosi;
      sck_oe <= next_sck_oe;
      mosi_oe <= next_mosi_oe;
      miso_oe <= next_miso_oe;
      sel_n_out <= next_sel_n;
    end
  end

  spp_buf u_rxbuf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(buf_in_valid),
    .in_data(buf_in),
    .in_ready(buf_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_word),
    .out_ready(rx_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // link domain: slave shifter, framed by ss_n_in
  always_comb begin
    next_l_bit = l_bit + 3'h1;
    next_l_rx_sr = {l_rx_sr[`SPP_WORD_W-2:0], mosi_in};
    next_l_rx_word = l_rx_word;
    next_l_tog = l_tog;
    next_l_tx_sr = (l_bit == 3'h0) ? {l_tx_word[`SPP_WORD_W-2:0], 1'b0} : {l_tx_sr[`SPP_WORD_W-2:0], 1'b0};
    next_l_tx_word = l_tx_word;
    next_l_ack = l_ack;
    if (ss_n_in) begin
      next_l_bit = 3'h0;
      next_l_rx_sr = l_rx_sr;
      next_l_tx_sr = l_tx_sr;
    end else if (l_bit == `SPP_LAST_BIT) begin
      next_l_rx_word = {l_rx_sr[`SPP_WORD_W-2:0], mosi_in};
      next_l_tog = !l_tog;
    end
    if (l_req2 != l_ack) begin
      next_l_tx_word = slv_tx_word;
      next_l_ack = !l_ack;
    end
    next_miso = (l_bit == 3'h0) ? l_tx_word[`SPP_WORD_W-1] : l_tx_sr[`SPP_WORD_W-1];
  end

  // link clock may be idle in reset: registered reset clears asynchronously
  always_ff @(posedge sck_link or posedge link_rst) begin
    if (link_rst) begin
      l_req1 <= 1'b0;
      l_req2 <= 1'b0;
      l_bit <= 3'h0;
      l_rx_sr <= '0;
      l_rx_word <= '0;
      l_tog <= 1'b0;
      l_tx_sr <= '0;
      l_tx_word <= '0;
      l_ack <= 1'b0;
    end else begin
      {l_req1, l_req2} <= {slv_req, l_req1};
      l_bit <= next_l_bit;
      l_rx_sr <= next_l_rx_sr;
      l_rx_word <= next_l_rx_word;
      l_tog <= next_l_tog;
      l_tx_sr <= next_l_tx_sr;
      l_tx_word <= next_l_tx_word;
      l_ack <= next_l_ack;
    end
  end

  always_ff @(negedge sck_link) begin
    miso_out <= next_miso;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [`SPP_EDGE_W-1:0] seen_edges;
  always_ff @(posedge clk) begin
    if (sys_rst || mst == spp_pkg::st_idle) seen_edges <= 5'h00;
    else if (next_sck != sck_out) seen_edges <= seen_edges + 5'h01;
  end

  property p_slave_stays; slave_run && !port_enable && !soft_reset_bit |=> slave_active; endproperty
  a_slave_stays: assert property (p_slave_stays) else $error("slave stopped without soft reset");
  property p_sel_field; buf_in_valid && buf_in_ready |-> buf_in.sel == hold_sel; endproperty
  a_sel_field: assert property (p_sel_field) else $error("select field source changed");
  property p_no_start; select_cfg[0].keep && !fault_detect_disable && mst == spp_pkg::st_idle |=> mst == spp_pkg::st_idle; endproperty
  a_no_start: assert property (p_no_start) else $error("transfer started with fault detect hang");
  property p_disable_flag; $fell(en_q) && !load_m && !slave_run |-> tx_holding_empty_flag == $past(tx_holding_empty_flag, 1); endproperty
  a_disable_flag: assert property (p_disable_flag) else $error("disable changed empty flag");
  property p_drop_write; tx_valid && !en_q && !slave_run && !soft_reset_bit && mst == spp_pkg::st_idle |=> $stable(tx_holding_empty_flag) && $stable(hold_data); endproperty
  a_drop_write: assert property (p_drop_write) else $error("write while disabled took effect");
  property p_dma_sink; !en_q |-> tx_ready; endproperty
  a_dma_sink: assert property (p_dma_sink) else $error("disabled port stalled writer");
  property p_extra_pulse; mst == spp_pkg::st_done |-> seen_edges == (extra ? `SPP_EDGES_EXTRA : `SPP_EDGES); endproperty
  a_extra_pulse: assert property (p_extra_pulse) else $error("wrong serial clock edge count");
  property p_write_clears;
    tx_valid && tx_ready && en_q && !soft_reset_bit |=> !tx_holding_empty_flag ##1
      (!tx_holding_empty_flag || $past(load_m) || slave_run || $past(soft_reset_bit));
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("accepted write did not clear flag");
  c_master_word: cover property (mst == spp_pkg::st_done ##1 rx_valid);
  c_extra: cover property (mst == spp_pkg::st_done && extra);
  c_slave_word: cover property (slave_run && buf_in_valid);
  c_buf_full: cover property (!buf_in_ready ##1 rx_valid && rx_ready);
endmodule

//--- testbench.sv
// self-checking bench: master transfers from a table, then hand tests
// assumes spp_consts.svh on the include path and the partner model
`include "spp_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: value mismatch %h vs %h", $time, (a), (b)); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] div;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic [7:0] odiv;
    logic [7:0] tx;
    logic [7:0] resp;
    logic [3:0] leads;
    logic chk;
  } spp_row_t;
  // sel, div, clock_polarity_bit, clock_phase_bit, other div, tx, reply, leading edges, data check
  spp_row_t rows [6] = '{
    '{2'h0, 8'h03, 1'b0, 1'b1, 8'h03, 8'ha5, 8'h3c, 4'h8, 1'b1},
    '{2'h1, 8'h04, 1'b1, 1'b0, 8'h04, 8'h5a, 8'hc3, 4'h8, 1'b1},
    '{2'h2, 8'h03, 1'b0, 1'b0, 8'h03, 8'h81, 8'h7e, 4'h8, 1'b1},
    '{2'h3, 8'h05, 1'b1, 1'b1, 8'h05, 8'h0f, 8'hf0, 4'h8, 1'b1},
    '{2'h1, 8'h01, 1'b1, 1'b0, 8'h01, 8'h66, 8'h00, 4'h8, 1'b0},
    '{2'h1, 8'h01, 1'b1, 1'b0, 8'h03, 8'h99, 8'h00, 4'h9, 1'b0}
  };
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic port_enable, soft_reset_bit, master_mode, fault_detect_disable, tx_valid, rx_ready;
  logic [7:0] tx_data;
  logic [1:0] tx_sel;
  spp_pkg::spp_sel_cfg_t [`SPP_NSEL-1:0] select_cfg;
  logic tx_ready, tx_holding_empty_flag, slave_active, rx_valid;
  spp_pkg::spp_rx_t rx_word;
  logic miso, sck_link, mosi_in, ss_n_in, sck_out, mosi_out, clock_polarity_bit, clock_phase_bit;
  logic [3:0] sel_n_out, seen_sel;
  logic [7:0] resp, got;
  logic [1:0] cur_sel;
  int leads, err_total, n_tests, cyc;
  spp_port spp_port_i (.clk(clk), .sys_rst(sys_rst), .sck_link(sck_link), .port_enable(port_enable),
    .soft_reset_bit(soft_reset_bit), .master_mode(master_mode), .fault_detect_disable(fault_detect_disable),
    .select_cfg(select_cfg), .tx_valid(tx_valid), .tx_data(tx_data), .tx_sel(tx_sel), .tx_ready(tx_ready),
    .tx_holding_empty_flag(tx_holding_empty_flag), .slave_active(slave_active), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_ready(rx_ready), .miso_in(miso), .mosi_in(mosi_in), .ss_n_in(ss_n_in),
    .sck_out(sck_out), .sck_oe(), .mosi_out(mosi_out), .mosi_oe(), .miso_out(), .miso_oe(),
    .sel_n_out(sel_n_out));
  spp_partner spp_partner_i (.sck(sck_out), .sel_n(sel_n_out[cur_sel]), .mosi(mosi_out), .clock_polarity_bit(clock_polarity_bit),
    .clock_phase_bit(clock_phase_bit), .resp(resp), .miso(miso), .sck_link(sck_link), .mosi_in(mosi_in), .ss_n_in(ss_n_in),
    .got(got));
  ////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end
  always @(sck_out) if (sel_n_out !== 4'hf && sck_out === ~clock_polarity_bit) leads++;
  always @(negedge clk) if (sel_n_out !== 4'hf) seen_sel = sel_n_out;
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cfg(input spp_row_t w);
    for (int i = 0; i < 4; i++) select_cfg[i] = '{(i == w.sel) ? w.div : w.odiv, w.clock_polarity_bit, w.clock_phase_bit, 1'b0};
    clock_polarity_bit = w.clock_polarity_bit;
    clock_phase_bit = w.clock_phase_bit;
    resp = w.resp;
    cur_sel = w.sel;
    leads = 0;
    tick(1);
  endtask
  task automatic wr(input logic [7:0] d, input logic [1:0] s, input logic fl);
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = d;
    tx_sel = s;
    do @(posedge clk); while (tx_ready !== 1'b1);
    @(negedge clk);
    tx_valid = 1'b0;
    `CHK(tx_holding_empty_flag, fl)
  endtask
  task automatic pop(input logic [7:0] d, input logic chk);
    int i;
    i = 0;
    @(negedge clk);
    while (rx_valid !== 1'b1 && i < 2000) begin
      @(negedge clk);
      i++;
    end
    if (i >= 2000) err_total++;
    if (chk) `CHK(rx_word.data, d)
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {port_enable, soft_reset_bit, master_mode, fault_detect_disable, tx_valid, rx_ready} = 6'h00;
    {tx_data, tx_sel, cur_sel, clock_polarity_bit, clock_phase_bit, resp} = 22'h000000;
    select_cfg = '0;
    seen_sel = 4'hf;
    {leads, err_total, n_tests, cyc} = {4{32'h00000000}};
    tick(10);
    `CHK({tx_ready, tx_holding_empty_flag, slave_active, rx_valid, sel_n_out}, 8'hcf)
    sys_rst = 1'b0;
    {master_mode, port_enable, fault_detect_disable} = 3'h7;
    tick(2);
    foreach (rows[r]) begin
      cfg(rows[r]);
      wr(rows[r].tx, rows[r].sel, 1'b0);
      pop(rows[r].resp, rows[r].chk);
      `CHK(leads, int'(rows[r].leads))
      `CHK(seen_sel, ~(4'h1 << rows[r].sel))
      if (rows[r].chk) `CHK(got, rows[r].tx)
    end
    // full receive buffer holds off the third start
    cfg(rows[0]);
    wr(8'h11, 2'h0, 1'b0);
    wr(8'h22, 2'h0, 1'b0);
    wr(8'h33, 2'h0, 1'b0);
    tick(150);
    `CHK({tx_holding_empty_flag, got}, 9'h022)
    repeat (3) pop(8'h3c, 1'b1);
    `CHK(got, 8'h33)
    // keep on select zero with fault detect on
    select_cfg[0].keep = 1'b1;
    fault_detect_disable = 1'b0;
    cur_sel = 2'h1;
    wr(8'h44, 2'h1, 1'b0);
    tick(100);
    `CHK({sel_n_out, tx_holding_empty_flag}, 5'h1e)
    port_enable = 1'b0;
    tick(3);
    `CHK(tx_holding_empty_flag, 1'b0)
    repeat (3) wr(8'h55, 2'h1, 1'b0);
    soft_reset_bit = 1'b1;
    tick(1);
    soft_reset_bit = 1'b0;
    tick(2);
    wr(8'h66, 2'h1, 1'b1);
    tick(100);
    `CHK({sel_n_out, rx_valid}, 5'h1e)
    fault_detect_disable = 1'b1;
    port_enable = 1'b1;
    tick(2);
    wr(8'h77, 2'h1, 1'b0);
    pop(8'h3c, 1'b1);
    `CHK(got, 8'h77)
    // slave mode survives disable until soft reset
    master_mode = 1'b0;
    tick(3);
    `CHK(slave_active, 1'b1)
    spp_partner_i.frame(8'hc9);
    pop(8'hc9, 1'b1);
    port_enable = 1'b0;
    tick(3);
    `CHK(slave_active, 1'b1)
    spp_partner_i.frame(8'h36);
    pop(8'h36, 1'b1);
    soft_reset_bit = 1'b1;
    tick(1);
    soft_reset_bit = 1'b0;
    tick(2);
    `CHK(slave_active, 1'b0)
    close_out();
  end
endmodule
